// *** src/psr_top.sv ***
// pll status readback register with avalon-mm slave and change interrupt
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/100ps

module psr_top (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // avalon-mm slave
  input  wire logic [psr_pkg::ADDR_W-1:0]  avs_address_i,
  input  wire logic                        avs_read_i,
  input  wire logic                        avs_write_i,
  input  wire logic [psr_pkg::DATA_W-1:0]  avs_writedata_i,
  input  wire logic [3:0]                  avs_byteenable_i,
  output logic      [psr_pkg::DATA_W-1:0]  avs_readdata_o,
  output logic                             avs_waitrequest_o,
  output logic                             irq_o,
  // monitored conditions from the pll, monitors and holdover logic
  input  wire logic                        secondary_reference_input_selected_i,
  input  wire logic                        vco_above_threshold_i,
  input  wire logic                        secondary_reference_input_above_i,
  input  wire logic                        primary_reference_input_above_i,
  input  wire logic                        pll_locked_i,
  input  wire logic                        vco_cal_done_i,
  input  wire logic                        holdover_active_i,
  // threshold choice handed to the secondary frequency monitor
  output logic                             secondary_reference_input_thr_sel_o
);
  typedef struct packed
  {
    psr_pkg::psr_bus_st_t        st;
    logic [psr_pkg::DATA_W-1:0]  rdata;
    logic                        thr_sel;
    logic [psr_pkg::EVT_W-1:0]   prev;
  } psr_top_st_t;

  psr_top_st_t q;
  psr_top_st_t next_q;

  logic [psr_pkg::EVT_W-1:0]  raw;
  logic [psr_pkg::EVT_W-1:0]  live;
  logic [psr_pkg::STAT_W-1:0] stat_word;
  logic [psr_pkg::IDX_W-1:0]  idx;
  logic [psr_pkg::DATA_W-1:0] rd_mux;
  logic                       req;
  logic                       in_ack;

  psr_irq_if irq_bus ();

  // monitors run off other clocks, so every level is synchronised first
  always_comb
  begin
    raw                           = '0;
    raw[psr_pkg::BIT_LOCKED]      = pll_locked_i;
    raw[psr_pkg::BIT_PRIM_ABOVE]  = primary_reference_input_above_i;
    raw[psr_pkg::BIT_SECD_ABOVE]  = secondary_reference_input_above_i;
    raw[psr_pkg::BIT_VCO_ABOVE]   = vco_above_threshold_i;
    raw[psr_pkg::BIT_SECD_SEL]    = secondary_reference_input_selected_i;
    raw[psr_pkg::BIT_HOLDOVER]    = holdover_active_i;
    raw[psr_pkg::BIT_CAL_DONE]    = vco_cal_done_i;
  end

  psr_sync #(
    .WIDTH (psr_pkg::EVT_W)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (raw),
    .q_o   (live)
  );

  // status word: live conditions, bit 7 reserved and reads zero
  always_comb
  begin
    stat_word                          = '0;
    stat_word[psr_pkg::BIT_LOCKED]     = live[psr_pkg::BIT_LOCKED];
    stat_word[psr_pkg::BIT_PRIM_ABOVE] = live[psr_pkg::BIT_PRIM_ABOVE];
    stat_word[psr_pkg::BIT_SECD_ABOVE] = live[psr_pkg::BIT_SECD_ABOVE];
    stat_word[psr_pkg::BIT_VCO_ABOVE]  = live[psr_pkg::BIT_VCO_ABOVE];
    stat_word[psr_pkg::BIT_SECD_SEL]   = live[psr_pkg::BIT_SECD_SEL];
    stat_word[psr_pkg::BIT_HOLDOVER]   = live[psr_pkg::BIT_HOLDOVER];
    stat_word[psr_pkg::BIT_CAL_DONE]   = live[psr_pkg::BIT_CAL_DONE];
  end

  // word decode; low two address bits are ignored
  assign idx    = avs_address_i[psr_pkg::ADDR_W-1:2];
  assign req    = avs_read_i | avs_write_i;
  assign in_ack = (q.st == psr_pkg::PSR_ST_ACK);

  // read mux; unmapped addresses read zero
  always_comb
  begin
    rd_mux = '0;
    case (idx)
      psr_pkg::IDX_PLL_STAT:
        rd_mux[psr_pkg::STAT_W-1:0] = stat_word;
      psr_pkg::IDX_REF_CFG:
        rd_mux[psr_pkg::BIT_SECD_THR_SEL] = q.thr_sel;
      psr_pkg::IDX_IRQ_STAT:
        rd_mux[psr_pkg::EVT_W-1:0] = irq_bus.sts;
      psr_pkg::IDX_IRQ_MASK:
        rd_mux[psr_pkg::EVT_W-1:0] = irq_bus.mask;
      default:
        rd_mux = '0;
    endcase
  end

  // one wait cycle: capture in idle, complete in ack
  always_comb
  begin
    next_q      = q;
    next_q.prev = live;
    case (q.st)
      psr_pkg::PSR_ST_IDLE:
      begin
        if (req)
        begin
          next_q.st = psr_pkg::PSR_ST_ACK;
          if (avs_read_i)
            next_q.rdata = rd_mux;
        end
      end
      psr_pkg::PSR_ST_ACK:
      begin
        next_q.st = psr_pkg::PSR_ST_IDLE;
        // the status word has no write path at all
        if (avs_write_i && idx == psr_pkg::IDX_REF_CFG && avs_byteenable_i[0])
          next_q.thr_sel = avs_writedata_i[psr_pkg::BIT_SECD_THR_SEL];
      end
      default:
        next_q.st = psr_pkg::PSR_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q.st      <= psr_pkg::PSR_ST_IDLE;
      q.rdata   <= psr_pkg::RST_RDATA;
      q.thr_sel <= psr_pkg::RST_SECD_THR_SEL;
      q.prev    <= '0;
    end
    else
      q <= next_q;
  end

  // any change of a monitored condition is an event
  assign irq_bus.evt = live ^ q.prev;

  // clear only the bits that were captured, so an event landing after capture survives
  assign irq_bus.clr = (in_ack && avs_read_i && idx == psr_pkg::IDX_IRQ_STAT)
                       ? q.rdata[psr_pkg::EVT_W-1:0] : '0;
  assign irq_bus.mask_we = in_ack && avs_write_i && idx == psr_pkg::IDX_IRQ_MASK && avs_byteenable_i[0];
  assign irq_bus.mask_wd = avs_writedata_i[psr_pkg::EVT_W-1:0];

  psr_irq u_irq (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .bus   (irq_bus)
  );

  // outputs
  assign avs_readdata_o                      = q.rdata;
  assign avs_waitrequest_o                   = ~in_ack;
  assign irq_o                               = irq_bus.irq;
  assign secondary_reference_input_thr_sel_o = q.thr_sel;
endmodule

// *** src/psr_pkg.sv ***
// constants and types shared by the pll status readback block
package psr_pkg;
  // avalon-mm slave geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W  = 6;
  localparam int unsigned STAT_W = 8;
  localparam int unsigned EVT_W  = 7;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_REF_CFG   = 6'h1a;
  localparam logic [IDX_W-1:0] IDX_PLL_STAT  = 6'h1f;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT  = 6'h20;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK  = 6'h21;

  // field positions in the status readback word
  localparam int unsigned BIT_LOCKED     = 0;
  localparam int unsigned BIT_PRIM_ABOVE = 1;
  localparam int unsigned BIT_SECD_ABOVE = 2;
  localparam int unsigned BIT_VCO_ABOVE  = 3;
  localparam int unsigned BIT_SECD_SEL   = 4;
  localparam int unsigned BIT_HOLDOVER   = 5;
  localparam int unsigned BIT_CAL_DONE   = 6;

  // field position of the secondary threshold select in the config word
  localparam int unsigned BIT_SECD_THR_SEL = 6;

  // reset values
  localparam logic             RST_SECD_THR_SEL = 1'b0;
  localparam logic [EVT_W-1:0] RST_IRQ_MASK     = 7'h00;
  localparam logic [EVT_W-1:0] RST_IRQ_STAT     = 7'h00;
  localparam logic [DATA_W-1:0] RST_RDATA       = 32'h0000_0000;

  // bus handshake state, one-hot
  typedef enum logic [1:0]
  {
    PSR_ST_IDLE = 2'b01,
    PSR_ST_ACK  = 2'b10
  } psr_bus_st_t;
endpackage

// *** src/psr_irq_if.sv ***
// carrier between the register front end and the interrupt unit
`timescale 1ns/100ps
interface psr_irq_if;
  logic [psr_pkg::EVT_W-1:0] evt;
  logic [psr_pkg::EVT_W-1:0] clr;
  logic                      mask_we;
  logic [psr_pkg::EVT_W-1:0] mask_wd;
  logic [psr_pkg::EVT_W-1:0] sts;
  logic [psr_pkg::EVT_W-1:0] mask;
  logic                      irq;

  modport ctl
  (
    output evt,
    output clr,
    output mask_we,
    output mask_wd,
    input  sts,
    input  mask,
    input  irq
  );

  modport unit
  (
    input  evt,
    input  clr,
    input  mask_we,
    input  mask_wd,
    output sts,
    output mask,
    output irq
  );
endinterface

// *** src/psr_sync.sv ***
// two-stage synchroniser for a vector of independent levels
`timescale 1ns/100ps
module psr_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  typedef struct packed
  {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } psr_sync_st_t;

  psr_sync_st_t q;
  psr_sync_st_t next_q;

  // first stage feeds only the second stage
  always_comb
  begin
    next_q    = q;
    next_q.s1 = d_i;
    next_q.s2 = q.s1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= next_q;
  end

  assign q_o = q.s2;
endmodule

// *** src/psr_irq.sv ***
// sticky event status, mask and level interrupt
`timescale 1ns/100ps
module psr_irq (
  input  wire logic clk_i,
  input  wire logic rst_i,
  psr_irq_if.unit   bus
);
  typedef struct packed
  {
    logic [psr_pkg::EVT_W-1:0] sts;
    logic [psr_pkg::EVT_W-1:0] mask;
  } psr_irq_st_t;

  psr_irq_st_t q;
  psr_irq_st_t next_q;

  // set wins over a clear arriving in the same cycle
  always_comb
  begin
    next_q     = q;
    next_q.sts = (q.sts & ~bus.clr) | bus.evt;
    if (bus.mask_we)
      next_q.mask = bus.mask_wd;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q.sts  <= psr_pkg::RST_IRQ_STAT;
      q.mask <= psr_pkg::RST_IRQ_MASK;
    end
    else
      q <= next_q;
  end

  // level output, high while any unmasked sticky bit stands
  assign bus.sts  = q.sts;
  assign bus.mask = q.mask;
  assign bus.irq  = |(q.sts & q.mask);
endmodule

// *** tb/psr_top_properties.sv ***
// concurrent checks on the pll status readback ports
`timescale 1ns/100ps
module psr_top_properties (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        secondary_reference_input_selected_i,
  input wire logic        vco_above_threshold_i,
  input wire logic        secondary_reference_input_above_i,
  input wire logic        primary_reference_input_above_i,
  input wire logic        pll_locked_i,
  input wire logic        vco_cal_done_i,
  input wire logic        holdover_active_i,
  input wire logic        secondary_reference_input_thr_sel_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // status read accepted by the idle slave
  sequence s_rd;
    avs_read_i && avs_waitrequest_o && avs_address_i[7:2] == 6'h1f;
  endsequence
  // captured bit is its input two sync stages before the capture edge
  property p_bit(int k, logic c);
    s_rd |=> avs_readdata_o[k] == $past(c, 3);
  endproperty
  AST_SEL: assert property (p_bit(4, secondary_reference_input_selected_i)) else $error("bit 4 wrong");
  AST_VCO: assert property (p_bit(3, vco_above_threshold_i)) else $error("bit 3 wrong");
  AST_SEC: assert property (p_bit(2, secondary_reference_input_above_i)) else $error("bit 2 wrong");
  AST_PRI: assert property (p_bit(1, primary_reference_input_above_i)) else $error("bit 1 wrong");
  AST_LOCK: assert property (p_bit(0, pll_locked_i)) else $error("bit 0 wrong");
  AST_CAL: assert property (p_bit(6, vco_cal_done_i)) else $error("bit 6 wrong");
  AST_HOLD: assert property (p_bit(5, holdover_active_i)) else $error("bit 5 wrong");
  AST_RO: assert property (s_rd |=> avs_readdata_o[31:7] == 25'h0) else $error("upper bits set");
  // config write completing with lane 0 enabled
  sequence s_cfg_wr;
    avs_write_i && !avs_waitrequest_o && avs_address_i[7:2] == 6'h1a && avs_byteenable_i[0];
  endsequence
  // threshold select follows a lane 0 config write
  AST_THR: assert property (s_cfg_wr |=> secondary_reference_input_thr_sel_o == $past(avs_writedata_i[6]))
    else $error("thr_sel wrong");
endmodule
bind psr_top psr_top_properties psr_top_properties_inst (.*);

// *** tb/psr_top_tb.sv ***
// self-checking bench for the pll status readback block
`timescale 1ns/100ps
module psr_top_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0]  be = 4'hf;
  logic [6:0]  cond = 7'h00;
  logic [31:0] rdata;
  logic        wreq;
  logic        irq;
  logic        thr;
  logic [31:0] q;
  int          errors = 0;
  int          total_checks = 0;
  int          m_sts = 0;
  int          m_mask = 0;

  psr_top psr_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .irq_o(irq), .pll_locked_i(cond[0]), .primary_reference_input_above_i(cond[1]),
    .secondary_reference_input_above_i(cond[2]), .vco_above_threshold_i(cond[3]),
    .secondary_reference_input_selected_i(cond[4]), .holdover_active_i(cond[5]),
    .vco_cal_done_i(cond[6]), .secondary_reference_input_thr_sel_o(thr));

  // close the run with counts and verdict
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // compare one value, four-state exact
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // one access held until waitrequest is seen low at a rising edge; data taken at that edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    rd <= !w;
    wr <= w;
    addr <= a;
    wd <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wreq !== 1'b0 && n < 40);
    if (wreq !== 1'b0)
    begin
      errors++;
      test_done;
    end
    else
    begin
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      // one idle edge so the next call never reassigns the strobes in this step
      @(posedge clk_i);
    end
  endtask

  // model: every change of a monitored level sets its sticky bit
  task automatic drive(input logic [6:0] v);
    m_sts = m_sts | int'(cond ^ v);
    cond <= v;
    repeat (4) @(posedge clk_i);
  endtask

  // interrupt level looked at mid-cycle
  task automatic ichk(input logic e);
    @(negedge clk_i);
    chk("irq", {31'h0, e}, {31'h0, irq});
    @(posedge clk_i);
  endtask

  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end

  initial
  begin
    void'($urandom(32'he2a06482));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    ichk(1'b0);
    chk("thr_sel", 32'h0, {31'h0, thr});
    // one condition at a time, then random mixes, held past the sync delay
    for (int i = 0; i < 23; i++)
    begin
      drive((i < 7) ? 7'h01 << i : 7'($urandom));
      bus(1'b0, 8'h7c, 32'h0);
      chk("status", {25'h0, cond}, q);
    end
    // write bounces off the readback word; rereads do not clear it
    bus(1'b1, 8'h7c, {25'h0, ~cond});
    bus(1'b0, 8'h7c, 32'h0);
    chk("status_ro", {25'h0, cond}, q);
    bus(1'b0, 8'h7c, 32'h0);
    chk("status_again", {25'h0, cond}, q);
    // threshold select set, then a write with lane 0 off is dropped
    bus(1'b1, 8'h68, 32'h40);
    chk("thr_sel", 32'h1, {31'h0, thr});
    be <= 4'he;
    bus(1'b1, 8'h68, 32'h0);
    be <= 4'hf;
    bus(1'b0, 8'h68, 32'h0);
    chk("cfg", 32'h40, q);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, q);
    // unmasking the bits left by the loop raises the line; the status read clears them
    bus(1'b1, 8'h84, 32'h7f);
    m_mask = 32'h7f;
    bus(1'b0, 8'h84, 32'h0);
    chk("irq_mask", m_mask, q);
    ichk((m_sts & m_mask) != 0);
    bus(1'b0, 8'h80, 32'h0);
    chk("irq_sts", m_sts, q);
    m_sts = 0;
    // unmasked change raises the interrupt until the status read
    drive(cond ^ 7'h01);
    ichk(1'b1);
    bus(1'b0, 8'h80, 32'h0);
    chk("irq_sts", m_sts, q);
    m_sts = 0;
    ichk(1'b0);
    // masked change leaves the line low but still sets its sticky bit
    bus(1'b1, 8'h84, 32'h0);
    m_mask = 0;
    drive(cond ^ 7'h40);
    ichk(1'b0);
    bus(1'b0, 8'h80, 32'h0);
    chk("irq_sts", m_sts, q);
    m_sts = 0;
    // mid-run reset: config and threshold select return to zero, held levels raise events again
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    m_sts = int'(cond);
    bus(1'b0, 8'h68, 32'h0);
    chk("cfg_rst", 32'h0, q);
    chk("thr_rst", 32'h0, {31'h0, thr});
    bus(1'b0, 8'h80, 32'h0);
    chk("irq_sts_rst", m_sts, q);
    ichk(1'b0);
    test_done;
  end
endmodule
